// ==== core/ext_media_cfg.svh ====
`ifndef EXT_MEDIA_CFG_SVH
`define EXT_MEDIA_CFG_SVH

// ==========================================================
// header dword
`define HDR_TYPE_VAL 3'h3
`define HDR_PIPE_VAL 2'h2
`define HDR_OPC_VAL 3'h1
`define HDR_SUBOPC_VAL 8'h01
`define HDR_MIN_LEN 16'h0003

// ==========================================================
// dword 2 and dword 3 fields
`define D2_SYNC_BIT 20
`define D2_MBZ_MASK 32'h80EE0000
`define ADDR_MBZ_MASK 32'hE0000000

// ==========================================================
// alignment masks on byte counts and addresses
`define ALIGN_DW_MASK 17'h00003
`define ALIGN_8DW_MASK 17'h0001F

// ==========================================================
// dispatch side
`define DESC_BYTES 32'h00000020
`define GRF_LAST 3'h7
`define QP_INLINE_IDX 16'h0001
`define QP_MASK 32'h000000FF

// ==========================================================
// issuer register word addresses
`define REG_DATA 2'h0
`define REG_STATUS 2'h1
`define REG_CTRL 2'h2

`endif

// ==== core/ext_media_decoder.sv ====
// The register offsets and the Avalon-MM register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "ext_media_cfg.svh"
// How it works
// - header type field must equal three
// - pipeline, opcode, subopcode must match exactly
// - total length is length field plus two
// - issuer always sends one inline dword minimum
// - accepted only in four codec/generic modes
// - issuer never sends in scaling or VLD
// - dword 1 goes to front end only
// - descriptor offset indexes from base pointer
// - descriptor chosen after offset remapping
// - bit 20 marks synchronized root thread
// - zero byte count disables indirect fetch
// - byte count aligned like start address
// - fetch address is base plus start
// - start address bits 31:29 kept zero
// - AVC transform order: vectors, weights, coefficients
// - AVC_MOTION_COMP_MODE order: vectors, weights, pixels
// - VC1 address points at first coefficient
// - inline raw in generic, parsed otherwise
// - reserved dword 2 bits written zero
// - AVC transform quantizer replaced by derived
// - inline packed, last register zero padded
module ext_media_decoder (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // command link
  ext_media_link_if.decoder link,
  // front end state
  input wire ext_media_pkg::fe_mode_t modeIn,
  input wire logic [31:0] descBase,
  input wire logic [31:0] objBase,
  input wire logic remapEn,
  input wire logic [6:0] remapDelta,
  input wire logic [7:0] derivedQp,
  // front end dword
  output logic [31:0] feDword,
  output logic feDwordValid,
  // indirect fetch
  output logic fetchValid,
  output logic fetchEn,
  output logic [31:0] fetchAddr,
  output logic [16:0] fetchLen,
  output ext_media_pkg::fetch_order_t fetchOrder,
  // thread dispatch
  output logic [31:0] descAddr,
  output logic syncRoot,
  output logic [31:0] payData,
  output logic payValid,
  output logic payLast,
  output logic payPad,
  output logic payRaw,
  output logic dispatch,
  // errors, one-cycle pulses
  output logic errHeader,
  output logic errMode,
  output logic errLength,
  output logic errAlign
);

  typedef enum {S_HEAD, S_FE, S_D2, S_D3, S_INL, S_PAD, S_DROP} state_t;

  state_t state_q, state_d;
  logic dwReady_q;
  ext_media_pkg::fe_mode_t feMode_q, pktMode_q;
  logic [16:0] remain_q;
  logic [2:0] grfCnt_q;
  logic [15:0] inlIdx_q;
  logic feDwordValid_q, fetchValid_q, fetchEn_q, syncRoot_q;
  logic [31:0] feDword_q, fetchAddr_q, descAddr_q, payData_q;
  logic [16:0] fetchLen_q;
  ext_media_pkg::fetch_order_t fetchOrder_q;
  logic payValid_q, payLast_q, payPad_q, payRaw_q, dispatch_q;
  logic errHeader_q, errMode_q, errLength_q, errAlign_q;
  logic take, hdrOk, modeOk, lenOk, lastIn;
  logic [15:0] lenField;

  // ==========================================================
  // decode helpers
  function automatic logic headerMatch(input logic [31:0] d);
    headerMatch = (d[31:29] == `HDR_TYPE_VAL) &&
      (d[28:27] == `HDR_PIPE_VAL) && (d[26:24] == `HDR_OPC_VAL) &&
      (d[23:16] == `HDR_SUBOPC_VAL);
  endfunction

  function automatic logic [6:0] remapDesc(input logic [6:0] off,
    input logic en, input logic [6:0] delta);
    remapDesc = en ? 7'(off + delta) : off;
  endfunction

  assign take = link.dwValid && dwReady_q;
  assign lenField = link.dwData[15:0];
  assign hdrOk = headerMatch(link.dwData);
  assign modeOk = ext_media_pkg::modeAllowed(feMode_q);
  assign lenOk = lenField >= `HDR_MIN_LEN;
  assign lastIn = remain_q == 17'h00001;

  // ==========================================================
  // packet sequencing
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      S_HEAD:
        if (take)
          state_d = (hdrOk && modeOk && lenOk) ? S_FE : S_DROP;
      S_FE:
        if (take)
          state_d = S_D2;
      S_D2:
        if (take)
          state_d = S_D3;
      S_D3:
        if (take)
          state_d = S_INL;
      S_INL:
        if (take && lastIn)
          state_d = (grfCnt_q == `GRF_LAST) ? S_HEAD : S_PAD;
      S_PAD:
        if (grfCnt_q == `GRF_LAST)
          state_d = S_HEAD;
      S_DROP:
        if (take && lastIn)
          state_d = S_HEAD;
      default:
        state_d = S_HEAD;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      state_q <= S_HEAD;
    else
      state_q <= state_d;
  end

  // stall the link while padding the last register
  always_ff @(posedge clk)
  begin
    if (rst)
      dwReady_q <= 1'b0;
    else
      dwReady_q <= state_d != S_PAD;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      feMode_q <= ext_media_pkg::GENERIC_MODE;
    else
      feMode_q <= modeIn;
  end

  // ==========================================================
  // counters
  always_ff @(posedge clk)
  begin
    if (rst)
      remain_q <= 17'h00000;
    else if (take && state_q == S_HEAD)
      remain_q <= 17'(lenField) + 17'h00001;
    else if (take)
      remain_q <= remain_q - 17'h00001;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      grfCnt_q <= 3'h0;
      inlIdx_q <= 16'h0000;
    end
    else if (state_q == S_D3)
    begin
      grfCnt_q <= 3'h0;
      inlIdx_q <= 16'h0000;
    end
    else if ((state_q == S_INL && take) || state_q == S_PAD)
    begin
      grfCnt_q <= grfCnt_q + 3'h1;
      inlIdx_q <= inlIdx_q + 16'h0001;
    end
  end

  // ==========================================================
  // header and fixed dwords
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pktMode_q <= ext_media_pkg::GENERIC_MODE;
      feDword_q <= 32'h00000000;
      descAddr_q <= 32'h00000000;
      syncRoot_q <= 1'b0;
      fetchLen_q <= 17'h00000;
      fetchEn_q <= 1'b0;
      fetchAddr_q <= 32'h00000000;
      fetchOrder_q <= ext_media_pkg::ORDER_RAW;
    end
    else if (take)
    begin
      case (state_q)
        S_HEAD:
          pktMode_q <= feMode_q;
        S_FE:
          feDword_q <= link.dwData;
        S_D2:
        begin
          descAddr_q <= descBase + 32'(remapDesc(link.dwData[30:24],
            remapEn, remapDelta)) * `DESC_BYTES;
          syncRoot_q <= link.dwData[`D2_SYNC_BIT];
          fetchLen_q <= link.dwData[16:0];
          fetchEn_q <= |link.dwData[16:0];
        end
        S_D3:
        begin
          // address ignored when nothing is fetched
          fetchAddr_q <= fetchEn_q ? objBase + link.dwData : 32'h00000000;
          case (pktMode_q)
            ext_media_pkg::AVC_TRANSFORM_MODE:
              fetchOrder_q <= ext_media_pkg::ORDER_MV_WO_COEF;
            ext_media_pkg::AVC_MOTION_COMP_MODE:
              fetchOrder_q <= ext_media_pkg::ORDER_MV_WO_PIXEL;
            ext_media_pkg::VC1_TRANSFORM_MODE:
              fetchOrder_q <= ext_media_pkg::ORDER_COEF_ONLY;
            default:
              fetchOrder_q <= ext_media_pkg::ORDER_RAW;
          endcase
        end
        default:
          fetchEn_q <= fetchEn_q;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      feDwordValid_q <= 1'b0;
      fetchValid_q <= 1'b0;
    end
    else
    begin
      feDwordValid_q <= take && state_q == S_FE;
      fetchValid_q <= take && state_q == S_D3 && fetchEn_q;
    end
  end

  // ==========================================================
  // inline payload
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      payData_q <= 32'h00000000;
      payValid_q <= 1'b0;
      payLast_q <= 1'b0;
      payPad_q <= 1'b0;
      payRaw_q <= 1'b0;
    end
    else
    begin
      payValid_q <= (take && state_q == S_INL) || state_q == S_PAD;
      payPad_q <= state_q == S_PAD;
      payLast_q <= state_d == S_HEAD &&
        (state_q == S_INL || state_q == S_PAD);
      payRaw_q <= pktMode_q == ext_media_pkg::GENERIC_MODE;
      if (state_q == S_PAD)
        payData_q <= 32'h00000000;
      else if (pktMode_q == ext_media_pkg::AVC_TRANSFORM_MODE &&
        inlIdx_q == `QP_INLINE_IDX)
        payData_q <= (link.dwData & ~`QP_MASK) | 32'(derivedQp);
      else
        payData_q <= link.dwData;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      dispatch_q <= 1'b0;
    else
      dispatch_q <= state_d == S_HEAD &&
        (state_q == S_INL || state_q == S_PAD);
  end

  // ==========================================================
  // error pulses; a broken packet is consumed by its length
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      errHeader_q <= 1'b0;
      errMode_q <= 1'b0;
      errLength_q <= 1'b0;
      errAlign_q <= 1'b0;
    end
    else
    begin
      errHeader_q <= take && state_q == S_HEAD && !hdrOk;
      errMode_q <= take && state_q == S_HEAD && !modeOk;
      errLength_q <= take && state_q == S_HEAD && !lenOk;
      errAlign_q <= take && ((state_q == S_D2 &&
        |(link.dwData[16:0] & ext_media_pkg::alignMask(pktMode_q))) ||
        (state_q == S_D3 && fetchEn_q &&
        |(link.dwData[16:0] & ext_media_pkg::alignMask(pktMode_q))));
    end
  end

  // ==========================================================
  // outputs
  assign link.dwReady = dwReady_q;
  assign link.feMode = feMode_q;
  assign feDword = feDword_q;
  assign feDwordValid = feDwordValid_q;
  assign fetchValid = fetchValid_q;
  assign fetchEn = fetchEn_q;
  assign fetchAddr = fetchAddr_q;
  assign fetchLen = fetchLen_q;
  assign fetchOrder = fetchOrder_q;
  assign descAddr = descAddr_q;
  assign syncRoot = syncRoot_q;
  assign payData = payData_q;
  assign payValid = payValid_q;
  assign payLast = payLast_q;
  assign payPad = payPad_q;
  assign payRaw = payRaw_q;
  assign dispatch = dispatch_q;
  assign errHeader = errHeader_q;
  assign errMode = errMode_q;
  assign errLength = errLength_q;
  assign errAlign = errAlign_q;

endmodule
`default_nettype wire

// ==== core/ext_media_issuer.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "ext_media_cfg.svh"
module ext_media_issuer (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // avalon-mm slave, word addressed
  input wire logic [1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // command link
  ext_media_link_if.issuer link
);

  logic busy_q, wait_q, valid_q;
  logic [31:0] data_q, rdata_q;
  logic inPkt_q, drop_q;
  logic [16:0] remain_q;
  logic [1:0] pos_q;
  logic noFetch_q;
  logic errMode_q, errShort_q, errAlign_q;
  logic start, dataWr, isHead, refuse, clr;
  logic [31:0] clean;

  assign start = !busy_q && wait_q && (avs_read || avs_write);
  assign dataWr = start && avs_write && avs_address == `REG_DATA;
  assign isHead = !inPkt_q;
  // never open a packet the decoder must refuse for its mode or length
  assign refuse = isHead && (!ext_media_pkg::modeAllowed(link.feMode) ||
    avs_writedata[15:0] < `HDR_MIN_LEN);
  assign clr = start && avs_write && avs_address == `REG_CTRL &&
    avs_writedata[0];

  always_comb
  begin
    clean = avs_writedata;
    if (inPkt_q && pos_q == 2'h2)
      clean = avs_writedata & ~`D2_MBZ_MASK;
    else if (inPkt_q && pos_q == 2'h3)
      clean = avs_writedata & ~`ADDR_MBZ_MASK;
  end

  // ==========================================================
  // bus handshake; forwarded data writes wait for the link to take them, refused ones end at once
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      busy_q <= 1'b0;
      wait_q <= 1'b1;
      valid_q <= 1'b0;
      data_q <= 32'h00000000;
      rdata_q <= 32'h00000000;
    end
    else
    begin
      wait_q <= 1'b1;
      if (!wait_q)
        busy_q <= 1'b0;
      if (start)
      begin
        busy_q <= 1'b1;
        // a refused packet must not swallow the next header
        if (dataWr && !(isHead ? refuse : drop_q))
        begin
          valid_q <= 1'b1;
          data_q <= clean;
        end
        else
          wait_q <= 1'b0;
        if (avs_read)
          rdata_q <= (avs_address == `REG_STATUS) ?
            {28'h0000000, valid_q, errAlign_q, errShort_q, errMode_q} :
            32'h00000000;
      end
      if (valid_q && link.dwReady)
      begin
        valid_q <= 1'b0;
        wait_q <= 1'b0;
      end
    end
  end

  // ==========================================================
  // packet tracking, by the length field
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      inPkt_q <= 1'b0;
      drop_q <= 1'b0;
      remain_q <= 17'h00000;
      pos_q <= 2'h0;
      noFetch_q <= 1'b0;
    end
    else if (dataWr)
    begin
      if (isHead)
      begin
        inPkt_q <= 1'b1;
        drop_q <= refuse;
        remain_q <= 17'(avs_writedata[15:0]) + 17'h00001;
        pos_q <= 2'h1;
      end
      else
      begin
        remain_q <= remain_q - 17'h00001;
        if (pos_q == 2'h2)
          noFetch_q <= ~|avs_writedata[16:0];
        if (pos_q != 2'h0)
          pos_q <= 2'(pos_q + 2'h1);
        if (remain_q == 17'h00001)
          inPkt_q <= 1'b0;
      end
    end
  end

  // ==========================================================
  // sticky status; a new event wins over a clear
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      errMode_q <= 1'b0;
      errShort_q <= 1'b0;
      errAlign_q <= 1'b0;
    end
    else
    begin
      errMode_q <= (dataWr && isHead &&
        !ext_media_pkg::modeAllowed(link.feMode)) || (errMode_q && !clr);
      errShort_q <= (dataWr && isHead &&
        avs_writedata[15:0] < `HDR_MIN_LEN) || (errShort_q && !clr);
      errAlign_q <= (dataWr && inPkt_q && !drop_q &&
        (pos_q == 2'h2 || (pos_q == 2'h3 && !noFetch_q)) &&
        |(avs_writedata[16:0] & ext_media_pkg::alignMask(link.feMode))) ||
        (errAlign_q && !clr);
    end
  end

  assign avs_readdata = rdata_q;
  assign avs_waitrequest = wait_q;
  assign link.dwValid = valid_q;
  assign link.dwData = data_q;

endmodule
`default_nettype wire

// ==== core/ext_media_link_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface ext_media_link_if (
  input wire logic clk
);
  logic dwValid;
  logic dwReady;
  logic [31:0] dwData;
  ext_media_pkg::fe_mode_t feMode;

  modport issuer (
    output dwValid,
    output dwData,
    input dwReady,
    input feMode
  );
  modport decoder (
    input dwValid,
    input dwData,
    output dwReady,
    output feMode
  );
endinterface
`default_nettype wire

// ==== core/ext_media_pkg.sv ====
`include "ext_media_cfg.svh"
package ext_media_pkg;

  typedef enum logic [2:0] {
    AVC_TRANSFORM_MODE,
    AVC_MOTION_COMP_MODE,
    VC1_TRANSFORM_MODE,
    GENERIC_MODE,
    IMAGE_SCALING_MODE,
    VARIABLE_LENGTH_DECODE_MODE
  } fe_mode_t;

  typedef enum logic [1:0] {
    ORDER_RAW,
    ORDER_MV_WO_COEF,
    ORDER_MV_WO_PIXEL,
    ORDER_COEF_ONLY
  } fetch_order_t;

  function automatic logic modeAllowed(input fe_mode_t m);
    modeAllowed = (m == AVC_TRANSFORM_MODE) || (m == AVC_MOTION_COMP_MODE) ||
      (m == VC1_TRANSFORM_MODE) || (m == GENERIC_MODE);
  endfunction

  function automatic logic [16:0] alignMask(input fe_mode_t m);
    alignMask = (m == AVC_MOTION_COMP_MODE) ? `ALIGN_8DW_MASK : `ALIGN_DW_MASK;
  endfunction

endpackage

// ==== testbench/ext_media_link_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "ext_media_cfg.svh"
module ext_media_link_chk (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // link
  input wire logic dwValid,
  input wire logic dwReady,
  input wire logic [31:0] dwData,
  input wire ext_media_pkg::fe_mode_t feMode,
  // decoder side
  input wire logic [31:0] feDword,
  input wire logic feDwordValid,
  input wire logic payValid,
  input wire logic payPad,
  input wire logic payLast,
  input wire logic dispatch
);
  logic take;
  logic [16:0] pktIdx_q;
  logic [15:0] pktLen_q;
  assign take = dwValid && dwReady;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // ==========================================================
  // position inside the packet
  always_ff @(posedge clk)
  begin
    if (rst)
      pktIdx_q <= 17'h00000;
    else if (take && pktIdx_q != 0 && pktIdx_q == {1'b0, pktLen_q} + 17'h1)
      pktIdx_q <= 17'h00000;
    else if (take)
      pktIdx_q <= pktIdx_q + 17'h00001;
  end
  always_ff @(posedge clk)
  begin
    if (rst)
      pktLen_q <= 16'h0000;
    else if (take && pktIdx_q == 0)
      pktLen_q <= dwData[15:0];
  end
  // ==========================================================
  // assertions
  sequence hdrTake;
    take && pktIdx_q == 0;
  endsequence
  sequence lastInline;
    take && pktIdx_q >= 4 && pktIdx_q == {1'b0, pktLen_q} + 17'h1;
  endsequence
  a_header_type: assert property (hdrTake |-> dwData[31:29] == 3'h3)
    else $error("header type field wrong");
  a_opcode_match: assert property (hdrTake |-> dwData[28:16] == 13'h1101)
    else $error("opcode fields wrong");
  a_min_length: assert property (hdrTake |-> dwData[15:0] >= 16'h0003)
    else $error("packet without inline data");
  a_mode_legal: assert property (hdrTake |-> feMode !=
    ext_media_pkg::IMAGE_SCALING_MODE &&
    feMode != ext_media_pkg::VARIABLE_LENGTH_DECODE_MODE)
    else $error("packet sent in disallowed mode");
  a_dw2_zero: assert property (take && pktIdx_q == 2 |->
    (dwData & `D2_MBZ_MASK) == 32'h00000000)
    else $error("reserved bits of dword 2 set");
  a_addr_range: assert property (take && pktIdx_q == 3 |->
    dwData[31:29] == 3'h0)
    else $error("start address beyond range");
  a_fe_dword: assert property (take && pktIdx_q == 1 |=>
    feDwordValid && feDword == $past(dwData))
    else $error("front end dword not delivered");
  a_inline_pay: assert property (take && pktIdx_q >= 4 |=>
    payValid && !payPad)
    else $error("inline dword not forwarded");
  a_dispatch_end: assert property (lastInline |-> ##[1:8]
    (dispatch && payLast))
    else $error("dispatch missing after payload");
  a_dispatch_last: assert property (dispatch |-> payLast && payValid)
    else $error("dispatch without last payload");
  a_offer_hold: assert property (dwValid && !dwReady |=>
    dwValid && $stable(dwData))
    else $error("offered dword dropped or changed");
endmodule
`default_nettype wire

// ==== testbench/extended_media_object_decoder_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "ext_media_cfg.svh"
module extended_media_object_decoder_tb_top;
  typedef struct {
    ext_media_pkg::fe_mode_t m;
    logic [15:0] len;
    logic [31:0] d2;
    logic [31:0] d3;
    logic [31:0] da;
    logic [31:0] fa;
  } row_t;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [1:0] avs_address = 2'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h00000000;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  ext_media_pkg::fe_mode_t modeIn = ext_media_pkg::GENERIC_MODE;
  logic [31:0] descBase = 32'h00400000;
  logic [31:0] objBase = 32'h00800000;
  logic remapEn = 1'b0;
  logic [6:0] remapDelta = 7'h03;
  logic [7:0] derivedQp = 8'h5A;
  logic [31:0] feDword, fetchAddr, descAddr, payData;
  logic [16:0] fetchLen;
  ext_media_pkg::fetch_order_t fetchOrder;
  logic feDwordValid, fetchValid, fetchEn, syncRoot, payValid, payLast;
  logic payPad, payRaw, dispatch, errHeader, errMode, errLength, errAlign;
  logic [31:0] payCap [16];
  row_t rows [4];
  int payN = 0, padN = 0, dispN = 0, alignN = 0, linkN = 0;
  int fetchN = 0, errN = 0;
  int fail_count = 0, samples_checked = 0;
  always #12.5 clk = ~clk;
  ext_media_link_if link (.clk(clk));
  ext_media_issuer ext_media_issuer_inst (.clk(clk), .rst(rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .link(link));
  ext_media_decoder ext_media_decoder_inst (.clk(clk), .rst(rst),
    .link(link), .modeIn(modeIn), .descBase(descBase), .objBase(objBase),
    .remapEn(remapEn), .remapDelta(remapDelta), .derivedQp(derivedQp),
    .feDword(feDword), .feDwordValid(feDwordValid), .fetchValid(fetchValid),
    .fetchEn(fetchEn), .fetchAddr(fetchAddr), .fetchLen(fetchLen),
    .fetchOrder(fetchOrder), .descAddr(descAddr), .syncRoot(syncRoot),
    .payData(payData), .payValid(payValid), .payLast(payLast),
    .payPad(payPad), .payRaw(payRaw), .dispatch(dispatch),
    .errHeader(errHeader), .errMode(errMode), .errLength(errLength),
    .errAlign(errAlign));
  ext_media_link_chk ext_media_link_chk_inst (.clk(clk), .rst(rst),
    .dwValid(link.dwValid), .dwReady(link.dwReady), .dwData(link.dwData),
    .feMode(link.feMode), .feDword(feDword), .feDwordValid(feDwordValid),
    .payValid(payValid), .payPad(payPad), .payLast(payLast),
    .dispatch(dispatch));
  // ==========================================================
  // monitor, blocking so tasks see it after #1
  always @(posedge clk)
  begin
    if (payValid === 1'b1)
    begin
      if (payN < 16) payCap[payN] = payData;
      payN++;
      if (payPad === 1'b1) padN++;
    end
    if (dispatch === 1'b1) dispN++;
    if (errAlign === 1'b1) alignN++;
    if (link.dwValid === 1'b1 && link.dwReady === 1'b1) linkN++;
    if (fetchValid === 1'b1) fetchN++;
    if ((errHeader | errMode | errLength) === 1'b1) errN++;
  end
  // ==========================================================
  // tasks
  task automatic wrap_up;
    $display("checks %0d errors %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic avXfer(input logic [1:0] a, input logic wr,
      input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    do
    begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 200);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 200)
    begin
      fail_count++;
      wrap_up();
    end
  endtask
  function automatic logic [31:0] inl(input int k);
    inl = 32'hC0DE0000 + 32'(k);
  endfunction
  // mode settles one cycle late on the link, so wait before the header
  task automatic sendPkt(input ext_media_pkg::fe_mode_t m, input logic rm,
      input logic [15:0] len, input logic [31:0] d1, input logic [31:0] d2,
      input logic [31:0] d3);
    logic [31:0] q;
    @(posedge clk);
    modeIn <= m;
    remapEn <= rm;
    repeat (2) @(posedge clk);
    #1;
    payN = 0;
    padN = 0;
    fetchN = 0;
    avXfer(`REG_DATA, 1'b1, {3'h3, 2'h2, 3'h1, 8'h01, len}, q);
    avXfer(`REG_DATA, 1'b1, d1, q);
    avXfer(`REG_DATA, 1'b1, d2, q);
    avXfer(`REG_DATA, 1'b1, d3, q);
    for (int k = 0; k < int'(len) - 2; k++)
      avXfer(`REG_DATA, 1'b1, inl(k), q);
  endtask
  task automatic waitDisp(input int target);
    int n;
    n = 0;
    while (dispN != target && n < 300)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n >= 300)
    begin
      fail_count++;
      wrap_up();
    end
  endtask
  // ==========================================================
  // main sequence
  initial
  begin
    logic [16:0] cnt;
    logic [31:0] q;
    int n, tot, seen;
    rows[0] = '{ext_media_pkg::AVC_TRANSFORM_MODE, 16'h0004, 32'h85300040,
      32'h00001000, 32'h004000A0, 32'h00801000};
    rows[1] = '{ext_media_pkg::AVC_MOTION_COMP_MODE, 16'h000B, 32'h7F000000,
      32'h12345678, 32'h00400040, 32'h00000000};
    rows[2] = '{ext_media_pkg::VC1_TRANSFORM_MODE, 16'h0003, 32'h0011FFFC,
      32'hFFFFFFFC, 32'h00400000, 32'h207FFFFC};
    rows[3] = '{ext_media_pkg::GENERIC_MODE, 16'h000A, 32'h40000020,
      32'h00000400, 32'h00400860, 32'h00800400};
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk(32'(avs_waitrequest), 32'h00000001);
    chk(32'(link.dwReady), 32'h00000000);
    chk(32'(link.feMode), 32'h00000003);
    for (int r = 0; r < 4; r++)
    begin
      sendPkt(rows[r].m, r[0], rows[r].len, 32'hFEED0000 + 32'(r),
        rows[r].d2, rows[r].d3);
      waitDisp(r + 1);
      cnt = rows[r].d2[16:0];
      n = int'(rows[r].len) - 2;
      tot = ((n + 7) / 8) * 8;
      chk(feDword, 32'hFEED0000 + 32'(r));
      chk(32'(syncRoot), 32'(rows[r].d2[20]));
      chk(32'(fetchEn), 32'(cnt != 17'h0));
      chk(32'(fetchLen), 32'(cnt));
      chk(32'(fetchN), 32'(cnt != 17'h0));
      chk(fetchAddr, rows[r].fa);
      chk(descAddr, rows[r].da);
      chk(32'(payRaw), 32'(rows[r].m == ext_media_pkg::GENERIC_MODE));
      // order codes follow the mode codes shifted by one
      if (cnt != 17'h0)
        chk(32'(fetchOrder), 32'(2'(rows[r].m + 3'h1)));
      chk(32'(payN), 32'(tot));
      chk(32'(padN), 32'(tot - n));
      chk(payCap[0], inl(0));
      if (n > 1)
        chk(payCap[1], (rows[r].m != ext_media_pkg::AVC_TRANSFORM_MODE) ?
          inl(1) : (inl(1) & 32'hFFFFFF00) | 32'(derivedQp));
      if (tot > n)
        chk(payCap[n], 32'h00000000);
    end
    // no flag from any row; a zero count ignores its address
    avXfer(`REG_STATUS, 1'b0, 32'h0, q);
    chk(q & 32'hF, 32'h00000000);
    // byte count dword aligned only, motion comp wants eight dwords
    sendPkt(ext_media_pkg::AVC_MOTION_COMP_MODE, 1'b0, 16'h0003, 32'h1,
      32'h00000024, 32'h00000100);
    waitDisp(5);
    chk(32'(alignN), 32'h00000001);
    avXfer(`REG_STATUS, 1'b0, 32'h0, q);
    chk(q & 32'h7, 32'h00000004);
    // refused packets: two banned modes, then too short
    for (int k = 0; k < 3; k++)
    begin
      avXfer(`REG_CTRL, 1'b1, 32'h00000001, q);
      seen = linkN;
      sendPkt((k < 2) ? ext_media_pkg::fe_mode_t'(3'(4 + k)) :
        ext_media_pkg::GENERIC_MODE, 1'b0, (k < 2) ? 16'h0003 : 16'h0002,
        32'h1, 32'h0, 32'h0);
      avXfer(`REG_STATUS, 1'b0, 32'h0, q);
      chk(q & 32'h7, (k < 2) ? 32'h1 : 32'h2);
      chk(32'(linkN - seen), 32'h00000000);
      chk(32'(dispN), 32'h00000005);
    end
    avXfer(`REG_CTRL, 1'b1, 32'h00000001, q);
    avXfer(`REG_STATUS, 1'b0, 32'h0, q);
    chk(q & 32'h7, 32'h00000000);
    avXfer(2'h3, 1'b0, 32'h0, q);
    chk(q, 32'h00000000);
    chk(32'(errN), 32'h00000000);
    wrap_up();
  end
endmodule
`default_nettype wire
